// file: src/cshp_pkg.sv
// Constants and carrier types for the channel status host port
package cshp_pkg;
   // ----------------------------------------------------------------
   // Serial control addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] CSHP_ADDR_TXCS = 8'hE9;
   localparam logic [7:0] CSHP_ADDR_DET  = 8'hEA;
   localparam logic [7:0] CSHP_ADDR_GP   = 8'hEB;
   localparam logic [7:0] CSHP_ADDR_RXCS = 8'hEC;
   localparam logic [7:0] CSHP_ADDR_PC   = 8'hED;
   // ----------------------------------------------------------------
   // Widths, header layout, counts
   // ----------------------------------------------------------------
   localparam int          CSHP_CS_BITS  = 48;
   localparam int          CSHP_HDR_BITS = 8;
   localparam int          CSHP_WR_BITS  = 56;
   localparam int          CSHP_PC_BITS  = 16;
   localparam int          CSHP_LEN_LSB  = 4;
   localparam int          CSHP_CHIP_LSB = 0;
   localparam logic [2:0]  CSHP_LEN_MAX  = 3'h5;
   localparam logic [5:0]  CSHP_CNT_MAX  = 6'h38;
   // Read bit positions in the detection register
   localparam int          CSHP_DET_ERR  = 8;
   localparam int          CSHP_DET_IC   = 9;
   localparam int          CSHP_DET_RATE = 10;
   localparam int          CSHP_DET_CS   = 11;
   localparam int          CSHP_DET_PC   = 13;
   localparam int          CSHP_DET_SLIP = 14;
   // ----------------------------------------------------------------
   // Reset values and the fixed test byte of the GP read-back
   // ----------------------------------------------------------------
   localparam logic [47:0] CSHP_TXCS_RST = 48'h0;
   localparam logic [7:0]  CSHP_ADDR_RST = 8'h00;
   localparam logic [7:0]  CSHP_TEST_VAL = 8'h00;

   // Read-back image, one field per read address
   typedef struct packed {
      logic [47:0] rxcs;
      logic [15:0] pc;
      logic [23:0] gp;
      logic [23:0] det;
   } cshp_img_t;

   // One-cycle event strobes from the receive side
   typedef struct packed {
      logic input_change;
      logic rate_update;
      logic slip;
   } cshp_evt_t;

   // Live status levels
   typedef struct packed {
      logic       rx_err;
      logic       nonlinear;
      logic       emphasis;
      logic       burst;
      logic       sync51;
      logic       sync61;
      logic [3:0] spacing;
   } cshp_live_t;
endpackage : cshp_pkg

// file: src/cshp_top.sv
// Serial host port: channel status write and four read-back registers
`timescale 1ns/1ns
module cshp_top
   import cshp_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        sclk,
   input  wire logic        ce,
   input  wire logic        di,
   input  wire logic [1:0]  chip_addr,
   output logic             dout,
   output logic             dout_oe_n,
   input  wire logic        input_monitor_enable,
   input  wire logic [6:0]  rx_active,
   input  wire logic        mod_output_active,
   input  wire logic        slave_mode,
   input  wire cshp_evt_t   evt,
   input  wire cshp_live_t  live,
   input  wire logic [3:0]  gp_input_level,
   input  wire logic [3:0]  rate_code,
   input  wire logic [7:0]  rate_counter_value,
   input  wire logic [47:0] rx_cs_in,
   input  wire logic        rx_blk_done,
   input  wire logic [15:0] pc_in,
   input  wire logic        pc_done,
   input  wire logic        blk_start,
   output logic [47:0]      tx_cs
);
   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Byte mask for a length code
   function automatic logic [47:0] cshp_len_mask(input logic [2:0] len);
      logic [47:0] m;
      m = '0;
      for (int i = 0; i < 6; i++) begin
         if (3'(i) <= len) begin
            m[i*8 +: 8] = 8'hFF;
         end
      end
      return m;
   endfunction : cshp_len_mask

   // Read bit selected by address and bit index
   function automatic logic cshp_rd_bit(input logic [7:0] a, input logic [5:0] k,
                                        input cshp_img_t im);
      logic b;
      b = 1'b0;
      case (a)
         CSHP_ADDR_DET:  b = (k < 6'd24) ? im.det[k[4:0]] : 1'b0;
         CSHP_ADDR_GP:   b = (k < 6'd24) ? im.gp[k[4:0]] : 1'b0;
         CSHP_ADDR_RXCS: b = (k < 6'd48) ? im.rxcs[k] : 1'b0;
         CSHP_ADDR_PC:   b = (k < 6'd16) ? im.pc[k[3:0]] : 1'b0;
         default:        b = 1'b0;
      endcase
      return b;
   endfunction : cshp_rd_bit

   function automatic logic cshp_is_rd(input logic [7:0] a);
      return (a == CSHP_ADDR_DET) || (a == CSHP_ADDR_GP) ||
             (a == CSHP_ADDR_RXCS) || (a == CSHP_ADDR_PC);
   endfunction : cshp_is_rd

   // ----------------------------------------------------------------
   // Link domain (sclk)
   // ----------------------------------------------------------------
   logic [7:0]  addr_r, addr_nxt;
   logic [5:0]  cnt_r, cnt_nxt;
   logic [55:0] wbits_r, wbits_nxt;
   logic        dout_r, dout_nxt;
   cshp_img_t   img_r;

   // Address phase with ce low, data phase with ce high
   always_comb begin
      addr_nxt  = addr_r;
      cnt_nxt   = cnt_r;
      wbits_nxt = wbits_r;
      dout_nxt  = dout_r;
      if (!ce) begin
         addr_nxt = {di, addr_r[7:1]};
         cnt_nxt  = '0;
      end else begin
         if (cnt_r < CSHP_CNT_MAX) begin
            cnt_nxt = cnt_r + 6'd1;
            if (addr_r == CSHP_ADDR_TXCS) begin
               wbits_nxt[cnt_r] = di;
            end
         end
         dout_nxt = cshp_rd_bit(addr_r, cnt_r, img_r);
      end
   end

   always_ff @(posedge sclk or negedge rstn) begin
      if (!rstn) begin
         addr_r  <= CSHP_ADDR_RST;
         cnt_r   <= '0;
         wbits_r <= '0;
         dout_r  <= 1'b0;
      end else begin
         addr_r  <= addr_nxt;
         cnt_r   <= cnt_nxt;
         wbits_r <= wbits_nxt;
         dout_r  <= dout_nxt;
      end
   end

   assign dout = dout_r;

   // ----------------------------------------------------------------
   // Chip enable and chip address synchronisers (mclk)
   // ----------------------------------------------------------------
   logic [2:0] ce_sy_r, ce_sy_nxt;
   logic       ce_s_r, ce_s_nxt;
   logic [1:0] ca1_r, ca2_r, ca3_r, ca_s_r, ca_s_nxt;
   logic       frame_end;

   // Level counts once stages two and three agree
   always_comb begin
      ce_sy_nxt = {ce_sy_r[1:0], ce};
      ce_s_nxt  = (ce_sy_r[1] == ce_sy_r[2]) ? ce_sy_r[2] : ce_s_r;
      ca_s_nxt  = (ca2_r == ca3_r) ? ca3_r : ca_s_r;
      frame_end = ce_s_r && !ce_s_nxt;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ce_sy_r <= '0;
         ce_s_r  <= 1'b0;
         ca1_r   <= '0;
         ca2_r   <= '0;
         ca3_r   <= '0;
         ca_s_r  <= '0;
      end else begin
         ce_sy_r <= ce_sy_nxt;
         ce_s_r  <= ce_s_nxt;
         ca1_r   <= chip_addr;
         ca2_r   <= ca1_r;
         ca3_r   <= ca2_r;
         ca_s_r  <= ca_s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Receive stores and event flags (mclk)
   // ----------------------------------------------------------------
   logic [47:0] rxcs_r, rxcs_nxt, prevcs_r, prevcs_nxt;
   logic [15:0] pc_r, pc_nxt, prevpc_r, prevpc_nxt;
   logic [4:0]  flg_r, flg_nxt;
   logic [4:0]  flg_set, flg_clr;
   cshp_img_t   img_nxt;
   logic        oe_n_r, oe_n_nxt;

   // Block compare, sticky events with set winning over read clear
   always_comb begin
      rxcs_nxt   = rxcs_r;
      prevcs_nxt = prevcs_r;
      pc_nxt     = pc_r;
      prevpc_nxt = prevpc_r;
      flg_set    = '0;
      if (rx_blk_done) begin
         prevcs_nxt = rx_cs_in;
         if (rx_cs_in == prevcs_r) begin
            rxcs_nxt   = rx_cs_in;
            flg_set[2] = 1'b1;
         end
      end
      if (pc_done) begin
         prevpc_nxt = pc_in;
         if (pc_in == prevpc_r) begin
            pc_nxt     = pc_in;
            flg_set[3] = 1'b1;
         end
      end
      flg_set[0] = evt.input_change;
      flg_set[1] = evt.rate_update;
      flg_set[4] = evt.slip && slave_mode;
      flg_clr = '0;
      if (frame_end && addr_r == CSHP_ADDR_DET) begin
         // Only bits shown in the frozen image are cleared
         flg_clr = {img_r.det[CSHP_DET_SLIP], img_r.det[CSHP_DET_PC],
                    img_r.det[CSHP_DET_CS], img_r.det[CSHP_DET_RATE],
                    img_r.det[CSHP_DET_IC]};
      end
      flg_nxt = (flg_r & ~flg_clr) | flg_set;
   end

   // Read image, frozen while a frame is open
   always_comb begin
      img_nxt = img_r;
      if (!ce_s_nxt && !ce_s_r) begin
         img_nxt.det[7:0] = input_monitor_enable ?
                            {mod_output_active, rx_active} : 8'h00;
         img_nxt.det[CSHP_DET_ERR]  = live.rx_err;
         img_nxt.det[CSHP_DET_IC]   = flg_r[0];
         img_nxt.det[CSHP_DET_RATE] = flg_r[1];
         img_nxt.det[CSHP_DET_CS]   = flg_r[2];
         img_nxt.det[12]            = live.nonlinear;
         img_nxt.det[CSHP_DET_PC]   = flg_r[3];
         img_nxt.det[CSHP_DET_SLIP] = flg_r[4];
         img_nxt.det[15]            = live.emphasis;
         img_nxt.det[16]            = rxcs_r[1];
         img_nxt.det[17]            = live.burst;
         img_nxt.det[18]            = live.sync51;
         img_nxt.det[19]            = live.sync61;
         img_nxt.det[23:20]         = live.spacing;
         img_nxt.gp   = {CSHP_TEST_VAL, rate_counter_value,
                         rate_code, gp_input_level};
         img_nxt.rxcs = rxcs_r;
         img_nxt.pc   = pc_r;
      end
      oe_n_nxt = !(ce_s_nxt && cshp_is_rd(addr_r));
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rxcs_r   <= '0;
         prevcs_r <= '0;
         pc_r     <= '0;
         prevpc_r <= '0;
         flg_r    <= '0;
         img_r    <= '0;
         oe_n_r   <= 1'b1;
      end else begin
         rxcs_r   <= rxcs_nxt;
         prevcs_r <= prevcs_nxt;
         pc_r     <= pc_nxt;
         prevpc_r <= prevpc_nxt;
         flg_r    <= flg_nxt;
         img_r    <= img_nxt;
         oe_n_r   <= oe_n_nxt;
      end
   end

   assign dout_oe_n = oe_n_r;

   // ----------------------------------------------------------------
   // Outgoing channel status store (mclk)
   // ----------------------------------------------------------------
   logic [47:0] pend_val_r, pend_val_nxt, tx_cs_r, tx_cs_nxt;
   logic        pend_r, pend_nxt;
   logic [2:0]  wlen;
   logic        wr_ok;
   logic [47:0] wmask;

   // Commit a checked write, apply it at the next block start
   always_comb begin
      wlen  = wbits_r[CSHP_LEN_LSB +: 3];
      wmask = cshp_len_mask(wlen);
      wr_ok = frame_end && (addr_r == CSHP_ADDR_TXCS) &&
              (wbits_r[CSHP_CHIP_LSB +: 2] == ca_s_r) &&
              (wlen <= CSHP_LEN_MAX) &&
              (cnt_r >= ({3'h0, wlen} + 6'd2) * 6'd8);
      pend_val_nxt = pend_val_r;
      pend_nxt     = pend_r;
      tx_cs_nxt    = tx_cs_r;
      if (blk_start && pend_r) begin
         tx_cs_nxt = pend_val_r;
         pend_nxt  = 1'b0;
      end
      if (wr_ok) begin
         pend_val_nxt = (pend_val_r & ~wmask) |
                        (wbits_r[CSHP_WR_BITS-1:CSHP_HDR_BITS] & wmask);
         pend_nxt     = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pend_val_r <= CSHP_TXCS_RST;
         pend_r     <= 1'b0;
         tx_cs_r    <= CSHP_TXCS_RST;
      end else begin
         pend_val_r <= pend_val_nxt;
         pend_r     <= pend_nxt;
         tx_cs_r    <= tx_cs_nxt;
      end
   end

   assign tx_cs = tx_cs_r;
endmodule : cshp_top

// file: tb/cshp_host_model.sv
// Host controller model for the serial control link
`timescale 1ns/1ns
module cshp_host_model (
   output logic      sclk,
   output logic      ce,
   output logic      di,
   input  wire logic dout
);
   // Link idle, clock stands still between frames
   initial begin
      sclk = 1'b0;
      ce = 1'b0;
      di = 1'b0;
   end

   // ----------------------------------------------------------------
   // One frame: address with ce low, n data edges with ce high
   // ----------------------------------------------------------------
   task automatic frame(input logic [7:0] addr, input int n, input logic [55:0] wd,
                        output logic [55:0] rd);
      rd = '0;
      // Offset moves link edges off the system clock grid; it adds up, so a fourth frame run back to back lands on it
      #3;
      for (int i = 0; i < 8; i++) begin
         di = addr[i];
         #24 sclk = 1'b1;
         #24 sclk = 1'b0;
      end
      ce = 1'b1;
      #80;
      for (int k = 0; k < n; k++) begin
         di = wd[k];
         #24;
         // Read bit sampled settled, just before the next rising edge
         if (k > 0) rd[k-1] = dout;
         sclk = 1'b1;
         #24 sclk = 1'b0;
      end
      #24 ce = 1'b0;
      di = ~di;
      #80;
   endtask : frame
endmodule : cshp_host_model

// file: tb/cshp_top_monitor.sv
// Port checker for the channel status host port
`timescale 1ns/1ns
module cshp_top_monitor (
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        ce,
   input wire logic        dout_oe_n,
   input wire logic        blk_start,
   input wire logic [47:0] tx_cs
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // ----------------------------------------------------------------
   // Outgoing status timing and read driver enable
   // ----------------------------------------------------------------
   tx_at_block_a: assert property ($changed(tx_cs) |-> $past(blk_start))
      else $error("tx_cs moved without a block start");
   tx_hold_a: assert property (blk_start ##1 blk_start |=> $stable(tx_cs))
      else $error("tx_cs moved on a repeated block start");
   oe_idle_a: assert property (!ce [*8] |-> dout_oe_n)
      else $error("read driver on while chip enable low");
   oe_release_a: assert property ($fell(ce) |-> ##[1:6] dout_oe_n)
      else $error("read driver not released after frame");
   oe_fall_a: assert property ($fell(dout_oe_n) |-> ce && $past(ce, 2))
      else $error("read driver on without a data phase");
   oe_rise_a: assert property ($rose(dout_oe_n) |-> !ce && !$past(ce, 2))
      else $error("read driver released inside a data phase");
   oe_delay_a: assert property ($rose(ce) |-> dout_oe_n [*2])
      else $error("read driver on too early");
   oe_steady_a: assert property (ce [*8] ##1 ce |-> $stable(dout_oe_n))
      else $error("read driver toggled inside a data phase");
endmodule : cshp_top_monitor

bind cshp_top cshp_top_monitor i_cshp_top_monitor (.mclk(mclk), .rstn(rstn), .ce(ce),
   .dout_oe_n(dout_oe_n), .blk_start(blk_start), .tx_cs(tx_cs));

// file: tb/cshp_top_tb_top.sv
// Self-checking bench for the channel status host port
`timescale 1ns/1ns
module cshp_top_tb_top;
   import cshp_pkg::*;
   logic        mclk, rstn, sclk, ce, di, dout, dout_oe_n, input_monitor_enable;
   logic        mod_output_active, slave_mode, rx_blk_done, pc_done, blk_start;
   logic [1:0]  chip_addr;
   logic [6:0]  rx_active;
   logic [3:0]  gp_input_level, rate_code;
   logic [7:0]  rate_counter_value;
   logic [15:0] pc_in;
   logic [47:0] rx_cs_in, tx_cs, exp_tx, pat;
   logic [23:0] det_exp;
   logic [55:0] v;
   cshp_evt_t   evt;
   cshp_live_t  live;
   int          failures, n_compared;

   cshp_top i_cshp_top (.mclk, .rstn, .sclk, .ce, .di, .chip_addr, .dout, .dout_oe_n,
      .input_monitor_enable, .rx_active, .mod_output_active, .slave_mode, .evt, .live,
      .gp_input_level, .rate_code, .rate_counter_value, .rx_cs_in, .rx_blk_done, .pc_in,
      .pc_done, .blk_start, .tx_cs);
   cshp_host_model i_cshp_host_model (.sclk, .ce, .di, .dout);

   // ----------------------------------------------------------------
   // Clock, helpers, verdict
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic check(input logic [55:0] seen, input logic [55:0] expv);
      n_compared++;
      if (seen !== expv) begin
         failures++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, expv);
      end
   endtask : check

   task automatic rd_reg(input logic [7:0] a, input int n);
      i_cshp_host_model.frame(a, n + 1, 56'h0, v);
   endtask : rd_reg

   task automatic wr_cs(input logic [1:0] ca, input logic [2:0] len, input logic [47:0] d);
      i_cshp_host_model.frame(CSHP_ADDR_TXCS, 56, {d, 1'b0, len, 2'h0, ca}, v);
   endtask : wr_cs

   task automatic pulse_blk();
      @(negedge mclk) blk_start = 1'b1;
      @(negedge mclk);
      @(negedge mclk) blk_start = 1'b0;
      @(negedge mclk);
   endtask : pulse_blk

   task automatic tally_and_finish();
      if (failures == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   // Watchdog against a hung link
   initial begin
      #300000;
      failures++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      {rstn, input_monitor_enable, mod_output_active, slave_mode} = 4'h0;
      {rx_blk_done, pc_done, blk_start, evt, live} = '0;
      chip_addr = 2'h2;
      rx_active = 7'h55;
      {gp_input_level, rate_code, rate_counter_value} = 16'h9B6D;
      rx_cs_in = 48'h9E3F_0C71_B25A;
      pc_in = 16'hC3E1;
      repeat (6) @(posedge mclk);
      @(negedge mclk) rstn = 1'b1;
      repeat (4) @(negedge mclk);
      check({8'h0, tx_cs}, 56'h0);
      exp_tx = '0;
      for (int c = 0; c < 6; c++) begin
         pat = ~exp_tx ^ 48'h5A3C_9617_E248;
         wr_cs(chip_addr, 3'(c), pat);
         check({8'h0, tx_cs}, {8'h0, exp_tx});
         for (int b = 0; b < 8 * (c + 1); b++) exp_tx[b] = pat[b];
         pulse_blk();
         check({8'h0, tx_cs}, {8'h0, exp_tx});
      end
      // Wrong chip address and both reserved lengths are refused
      for (int i = 0; i < 3; i++) wr_cs(i == 0 ? ~chip_addr : chip_addr, 3'(5 + i), 48'h0);
      pulse_blk();
      check({8'h0, tx_cs}, {8'h0, exp_tx});
      @(negedge mclk) {input_monitor_enable, mod_output_active, slave_mode} = 3'h7;
      live = 10'h3DA;
      repeat (2) begin
         @(negedge mclk) {evt, rx_blk_done, pc_done} = 5'h1F;
         @(negedge mclk) {evt, rx_blk_done, pc_done} = 5'h00;
      end
      det_exp = {live.spacing, live.sync61, live.sync51, live.burst, rx_cs_in[1],
                 live.emphasis, 2'h3, live.nonlinear, 3'h7, live.rx_err, 1'b1, rx_active};
      rd_reg(CSHP_ADDR_DET, 24);
      check(v, {32'h0, det_exp});
      @(negedge mclk) input_monitor_enable = 1'b0;
      rd_reg(CSHP_ADDR_DET, 24);
      check(v, {32'h0, det_exp & ~24'h006EFF});
      rd_reg(CSHP_ADDR_GP, 24);
      check(v, {40'h0, rate_counter_value, rate_code, gp_input_level});
      rd_reg(CSHP_ADDR_RXCS, 48);
      check(v, {8'h0, rx_cs_in});
      rd_reg(CSHP_ADDR_PC, 16);
      check(v, {40'h0, pc_in});
      rd_reg(8'hEE, 24);
      check(v, 56'h0);
      // Slip ignored outside slave mode; an event during a read survives it
      @(negedge mclk) {slave_mode, evt} = 4'h5;
      @(negedge mclk) {slave_mode, evt} = 4'h0;
      fork
         rd_reg(CSHP_ADDR_DET, 24);
         begin
            #1200;
            @(negedge mclk) evt = 3'h2;
            @(negedge mclk) evt = 3'h0;
         end
      join
      check(v, {32'h0, det_exp & ~24'h006EFF | 24'h000200});
      rd_reg(CSHP_ADDR_DET, 24);
      check(v, {32'h0, det_exp & ~24'h006EFF | 24'h000400});
      tally_and_finish();
   end
endmodule : cshp_top_tb_top
